// *** hw/scnh_pkg.sv ***
`default_nettype none
package scnh_pkg;
  localparam int CLK_HZ      = 25_000_000;
  localparam int TRIG_MIN_MS = 10;
  localparam int RST_MIN_US  = 100;
  localparam int RST_MAX_US  = 500;
  localparam int RST_GAP_S   = 2;
  localparam int LED_MS      = 20;
  localparam int BEEP_MS     = 100;
  localparam int TONE_HZ     = 2700;
  localparam int TRIG_CYC    = TRIG_MIN_MS * (CLK_HZ / 1000);
  localparam int RST_MIN_CYC = (RST_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int RST_MAX_CYC = RST_MAX_US * (CLK_HZ / 1000) / 1000;
  localparam int RST_GAP_CYC = RST_GAP_S * CLK_HZ + 1;
  localparam int LED_CYC     = LED_MS * (CLK_HZ / 1000);
  localparam int BEEP_CYC    = BEEP_MS * (CLK_HZ / 1000);
  localparam int TONE_CYC    = CLK_HZ / (2 * TONE_HZ);
  localparam int CW          = 27;
  localparam int BAUD_MIN_BPS = 1200;
  localparam int BAUD_MAX_BPS = 115200;
  localparam int BAUD_DEF_BPS = 9600;
  localparam int DW          = 15;
  localparam logic [DW-1:0] DIV_DEF = DW'(CLK_HZ / BAUD_DEF_BPS);
  localparam logic [DW-1:0] DIV_MAX = DW'(CLK_HZ / BAUD_MIN_BPS);
  localparam logic [DW-1:0] DIV_MIN = DW'(CLK_HZ / BAUD_MAX_BPS);
  localparam int FRAME_BITS  = 10;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_BAUD   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BEEP_BIT = 2;
  localparam logic       CTRL_BEEP_RST = 1'b1;
  typedef enum logic [1:0] {
    keyboard_emulation_mode,
    serial_port_mode,
    point_of_sale_hid_mode
  } scnh_usb_mode_t;
  localparam scnh_usb_mode_t CTRL_MODE_RST = keyboard_emulation_mode;
  typedef enum logic [2:0] {st_hold, st_idle, st_arm, st_scan, st_send} scnh_state_t;
endpackage : scnh_pkg
`default_nettype wire

// *** hw/scnh_engine.sv ***
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - A scan session starts once the trigger has been held low for more than 10 ms.
// - After a decode the data goes to the host and the engine then waits for trigger release.
// - Releasing the trigger during a scan attempt aborts decoding at once.
// - A new session needs a fresh low assertion of the trigger.
// - The serial link runs at a chosen rate from 1200 to 115200 bit/s.
// - The serial link has no hardware flow control.
// - After reset the serial link runs at 9600 baud, 8 data bits, no parity, 1 stop bit.
// - Each good read drives the good-read output high for a pulse, then low.
// - The beeper output carries a PWM tone on power-up and on a good read.
// - Over USB the engine offers keyboard, virtual serial port and point-of-sale HID modes.
module scnh_engine #(
  parameter int TRIG_P = scnh_pkg::TRIG_CYC,
  parameter int RMAX_P = scnh_pkg::RST_MAX_CYC,
  parameter int GAP_P  = scnh_pkg::RST_GAP_CYC,
  parameter int LED_P  = scnh_pkg::LED_CYC,
  parameter int BEEP_P = scnh_pkg::BEEP_CYC,
  parameter int TONE_P = scnh_pkg::TONE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        scan_trigger_n,
  input  wire logic        host_reset_n,
  input  wire logic        uart_rx,
  input  wire logic        dec_valid,
  input  wire logic [7:0]  dec_data,
  input  wire logic        dec_last,
  output var  logic        dec_ready,
  output var  logic        scan_active,
  output var  logic        scan_abort,
  output var  logic        engine_reset,
  output var  logic        uart_tx,
  output var  logic        good_read_led,
  output var  logic        beeper_pwm,
  output var  logic [1:0]  usb_mode
);
  import scnh_pkg::*;

  localparam logic [CW-1:0] TRIG_C = CW'(TRIG_P);
  localparam logic [CW-1:0] RMIN_C = CW'(RST_MIN_CYC);
  localparam logic [CW-1:0] RMAX_C = CW'(RMAX_P);
  localparam logic [CW-1:0] GAP_C  = CW'(GAP_P);
  localparam logic [CW-1:0] LED_C  = CW'(LED_P);
  localparam logic [CW-1:0] BEEP_C = CW'(BEEP_P);
  localparam logic [CW-1:0] TONE_C = CW'(TONE_P);

  // Pin synchronisers: bit 0 trigger, bit 1 reset, bit 2 serial receive.
  logic [2:0] pin_in;
  logic [2:0] s0_r, s1_r, s2_r, lvl_r, lvl_nxt;
  assign pin_in = {uart_rx, host_reset_n, scan_trigger_n};

  for (genvar g = 0; g < 3; g++)
  begin : g_sync
    always_comb lvl_nxt[g] = (s1_r[g] == s2_r[g]) ? s2_r[g] : lvl_r[g];
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s0_r  <= 3'h7;
      s1_r  <= 3'h7;
      s2_r  <= 3'h7;
      lvl_r <= 3'h7;
    end
    else
    begin
      s0_r  <= pin_in;
      s1_r  <= s0_r;
      s2_r  <= s1_r;
      lvl_r <= lvl_nxt;
    end
  end

  logic trig_low;
  assign trig_low = ~lvl_r[0];

  // Reset pin qualification: pulse length window and spacing since the last accepted one.
  logic [CW-1:0] rlow_r, rlow_nxt, gap_r, gap_nxt;
  logic          erst_r, erst_nxt;

  always_comb
  begin
    rlow_nxt = rlow_r;
    gap_nxt  = (gap_r < GAP_C) ? gap_r + 1'b1 : gap_r;
    erst_nxt = 1'b0;
    if (!lvl_r[1])
    begin
      if (rlow_r <= RMAX_C)
        rlow_nxt = rlow_r + 1'b1;
    end
    else if (rlow_r != '0)
    begin
      rlow_nxt = '0;
      if (rlow_r >= RMIN_C && rlow_r <= RMAX_C && gap_r == GAP_C)
      begin
        erst_nxt = 1'b1;
        gap_nxt  = '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rlow_r <= '0;
      gap_r  <= GAP_C;
      erst_r <= 1'b0;
    end
    else
    begin
      rlow_r <= rlow_nxt;
      gap_r  <= gap_nxt;
      erst_r <= erst_nxt;
    end
  end

  // Register slave: every access is answered with waitrequest low one cycle after it appears.
  logic [31:0]    rdata_r, rdata_nxt;
  logic           wait_r, wait_nxt;
  scnh_usb_mode_t mode_r, mode_nxt;
  logic           beep_en_r, beep_en_nxt;
  logic [DW-1:0]  div_r, div_nxt;
  logic [7:0]     reads_r, reads_nxt;
  scnh_state_t    state_r, state_nxt;
  logic [1:0]     cnt_r, cnt_nxt;
  logic           busy_r;
  logic           wr_ok;
  logic [DW-1:0]  wdiv;
  assign wr_ok = avs_write && !wait_r;
  assign wdiv  = avs_writedata[DW-1:0];

  function automatic logic [31:0] reg_read(input logic [3:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      ADDR_CTRL:   v = {29'h0, beep_en_r, mode_r};
      ADDR_BAUD:   v = {17'h0, div_r};
      ADDR_STATUS: v = {16'h0, reads_r, lvl_r[2], busy_r, cnt_r, trig_low, state_r};
      default:     v = '0;
    endcase
    return v;
  endfunction : reg_read

  always_comb
  begin
    wait_nxt    = 1'b1;
    rdata_nxt   = rdata_r;
    mode_nxt    = mode_r;
    beep_en_nxt = beep_en_r;
    div_nxt     = div_r;
    if (wait_r && (avs_read || avs_write))
    begin
      wait_nxt = 1'b0;
      if (avs_read)
        rdata_nxt = reg_read(avs_address);
    end
    if (wr_ok && avs_address == ADDR_CTRL)
    begin
      if (avs_writedata[CTRL_MODE_LSB +: 2] != 2'h3)
        mode_nxt = scnh_usb_mode_t'(avs_writedata[CTRL_MODE_LSB +: 2]);
      beep_en_nxt = avs_writedata[CTRL_BEEP_BIT];
    end
    if (wr_ok && avs_address == ADDR_BAUD && wdiv >= DIV_MIN && wdiv <= DIV_MAX)
      div_nxt = wdiv;
    if (erst_r)
    begin
      mode_nxt    = CTRL_MODE_RST;
      beep_en_nxt = CTRL_BEEP_RST;
      div_nxt     = DIV_DEF;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_r    <= 1'b1;
      rdata_r   <= '0;
      mode_r    <= CTRL_MODE_RST;
      beep_en_r <= CTRL_BEEP_RST;
      div_r     <= DIV_DEF;
    end
    else
    begin
      wait_r    <= wait_nxt;
      rdata_r   <= rdata_nxt;
      mode_r    <= mode_nxt;
      beep_en_r <= beep_en_nxt;
      div_r     <= div_nxt;
    end
  end

  // Session control and the two-entry buffer between decoder and serial transmitter.
  logic [CW-1:0] trig_r, trig_nxt;
  logic          last_r, last_nxt, rdy_r, rdy_nxt, act_r, act_nxt, abort_r, abort_nxt;
  logic          push, pop, gr_evt;
  logic [8:0]    mem_r [2];
  logic          wp_r, wp_nxt, rp_r, rp_nxt;
  assign push = dec_valid && rdy_r;

  always_comb
  begin
    state_nxt = state_r;
    trig_nxt  = trig_r;
    last_nxt  = last_r;
    abort_nxt = 1'b0;
    gr_evt    = 1'b0;
    unique case (state_r)
      st_hold: if (!trig_low) state_nxt = st_idle;
      st_idle:
        if (trig_low)
        begin
          state_nxt = st_arm;
          trig_nxt  = '0;
        end
      st_arm:
        if (!trig_low)
          state_nxt = st_idle;
        else if (trig_r == TRIG_C - 1'b1)
          state_nxt = st_scan;
        else
          trig_nxt = trig_r + 1'b1;
      st_scan:
        if (push)
        begin
          state_nxt = st_send;
          last_nxt  = dec_last;
          gr_evt    = 1'b1;
        end
        else if (!trig_low)
        begin
          state_nxt = st_idle;
          abort_nxt = 1'b1;
        end
      st_send:
      begin
        if (push && dec_last)
          last_nxt = 1'b1;
        if (last_r && cnt_r == 2'h0 && !busy_r)
        begin
          state_nxt = st_hold;
          last_nxt  = 1'b0;
        end
      end
    endcase
    if (erst_r)
    begin
      state_nxt = st_hold;
      last_nxt  = 1'b0;
      gr_evt    = 1'b0;
    end
    act_nxt = state_nxt == st_scan;
    reads_nxt = reads_r + (gr_evt ? 8'h01 : 8'h00);
    wp_nxt  = erst_r ? 1'b0 : wp_r ^ push;
    rp_nxt  = erst_r ? 1'b0 : rp_r ^ pop;
    cnt_nxt = erst_r ? 2'h0 : cnt_r + {1'b0, push} - {1'b0, pop};
    rdy_nxt = cnt_nxt != 2'h2 && (state_nxt == st_scan || state_nxt == st_send);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= st_hold;
      trig_r  <= '0;
      last_r  <= 1'b0;
      abort_r <= 1'b0;
      act_r   <= 1'b0;
      reads_r <= '0;
      wp_r    <= 1'b0;
      rp_r    <= 1'b0;
      cnt_r   <= 2'h0;
      rdy_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      trig_r  <= trig_nxt;
      last_r  <= last_nxt;
      abort_r <= abort_nxt;
      act_r   <= act_nxt;
      reads_r <= reads_nxt;
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      cnt_r   <= cnt_nxt;
      rdy_r   <= rdy_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_r[wp_r] <= {dec_last, dec_data};
  end

  // Serial transmitter, 8N1, free running: the far end cannot hold it off.
  logic [DW-1:0] bcnt_r, bcnt_nxt;
  logic [3:0]    bit_r, bit_nxt;
  logic [9:0]    sh_r, sh_nxt;
  logic          busy_nxt, tx_r, tx_nxt;
  assign pop = !busy_r && cnt_r != 2'h0 && !erst_r;

  always_comb
  begin
    bcnt_nxt = bcnt_r;
    bit_nxt  = bit_r;
    sh_nxt   = sh_r;
    busy_nxt = busy_r;
    if (pop)
    begin
      busy_nxt = 1'b1;
      sh_nxt   = {1'b1, mem_r[rp_r][7:0], 1'b0};
      bit_nxt  = '0;
      bcnt_nxt = div_r - 1'b1;
    end
    else if (busy_r)
    begin
      if (bcnt_r != '0)
        bcnt_nxt = bcnt_r - 1'b1;
      else if (bit_r == 4'(FRAME_BITS - 1))
        busy_nxt = 1'b0;
      else
      begin
        sh_nxt   = {1'b1, sh_r[9:1]};
        bit_nxt  = bit_r + 1'b1;
        bcnt_nxt = div_r - 1'b1;
      end
    end
    tx_nxt = busy_nxt ? sh_nxt[0] : 1'b1;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bcnt_r <= '0;
      bit_r  <= '0;
      sh_r   <= 10'h3FF;
      busy_r <= 1'b0;
      tx_r   <= 1'b1;
    end
    else
    begin
      bcnt_r <= bcnt_nxt;
      bit_r  <= bit_nxt;
      sh_r   <= sh_nxt;
      busy_r <= busy_nxt;
      tx_r   <= tx_nxt;
    end
  end

  // Good-read pulse and beeper tone; the beeper also sounds after power-up and engine reset.
  logic [CW-1:0] led_r, led_nxt, beep_r, beep_nxt, tone_r, tone_nxt;
  logic          led_o_r, led_o_nxt, ph_r, ph_nxt, bz_r, bz_nxt;

  always_comb
  begin
    led_nxt  = gr_evt ? LED_C : (led_r != '0 ? led_r - 1'b1 : led_r);
    beep_nxt = (gr_evt || erst_r) ? BEEP_C : (beep_r != '0 ? beep_r - 1'b1 : beep_r);
    tone_nxt = (tone_r == '0) ? TONE_C - 1'b1 : tone_r - 1'b1;
    ph_nxt   = (tone_r == '0) ? !ph_r : ph_r;
    led_o_nxt = led_nxt != '0;
    bz_nxt   = ph_nxt && beep_nxt != '0 && beep_en_r;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      led_r   <= '0;
      beep_r  <= BEEP_C;
      tone_r  <= '0;
      ph_r    <= 1'b0;
      led_o_r <= 1'b0;
      bz_r    <= 1'b0;
    end
    else
    begin
      led_r   <= led_nxt;
      beep_r  <= beep_nxt;
      tone_r  <= tone_nxt;
      ph_r    <= ph_nxt;
      led_o_r <= led_o_nxt;
      bz_r    <= bz_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign dec_ready       = rdy_r;
  assign scan_active     = act_r;
  assign scan_abort      = abort_r;
  assign engine_reset    = erst_r;
  assign uart_tx         = tx_r;
  assign good_read_led   = led_o_r;
  assign beeper_pwm      = bz_r;
  assign usb_mode        = mode_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_start_after_hold;
    $rose(act_r) |-> $past(state_r) == st_arm && $past(trig_r) == TRIG_C - 1'b1 && $past(trig_low);
  endproperty
  a_start_after_hold: assert property (p_start_after_hold) else $error("scan began early");
  property p_abort_now;
    state_r == st_scan && !trig_low && !push && !erst_r |=> abort_r && !act_r && state_r == st_idle;
  endproperty
  a_abort_now: assert property (p_abort_now) else $error("release did not abort");
  property p_hold_until_release;
    state_r == st_hold && trig_low && !erst_r |=> state_r == st_hold;
  endproperty
  a_hold_until_release: assert property (p_hold_until_release) else $error("left hold early");
  property p_fresh_low;
    state_r == st_idle ##1 state_r == st_arm |-> $past(trig_low);
  endproperty
  a_fresh_low: assert property (p_fresh_low) else $error("arm without low");
  property p_led_rise;
    $rose(good_read_led) |-> $past(state_r) == st_scan && $past(push);
  endproperty
  a_led_rise: assert property (p_led_rise) else $error("led without read");
  property p_led_width;
    $rose(good_read_led) |-> led_r == LED_C;
  endproperty
  a_led_width: assert property (p_led_width) else $error("led pulse length wrong");
  property p_default_rate;
    erst_r |=> div_r == DIV_DEF && mode_r == CTRL_MODE_RST;
  endproperty
  a_default_rate: assert property (p_default_rate) else $error("defaults not restored");
  property p_rate_range;
    div_r >= DIV_MIN && div_r <= DIV_MAX;
  endproperty
  a_rate_range: assert property (p_rate_range) else $error("baud divisor out of range");
  property p_reset_window;
    $rose(erst_r) |-> $past(rlow_r) >= RMIN_C && $past(rlow_r) <= RMAX_C;
  endproperty
  a_reset_window: assert property (p_reset_window) else $error("bad reset pulse accepted");
  property p_mode_legal;
    usb_mode != 2'h3;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal usb mode");
  property p_beep_quiet;
    beep_r == '0 |-> !beeper_pwm;
  endproperty
  a_beep_quiet: assert property (p_beep_quiet) else $error("beeper active outside event");
  property p_bus_answer;
    wait_r && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");
  c_scan: cover property ($rose(act_r));
  c_abort: cover property (abort_r);
  c_read_done: cover property (state_r == st_send ##1 state_r == st_hold);
  c_eng_rst: cover property (erst_r);
endmodule : scnh_engine
`default_nettype wire

// *** verification/scnh_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// Host controller model: drives the trigger, the reset pin and the receive line.
// It also decodes the engine's serial output.
module scnh_host (
  input  wire logic sys_clk,
  input  wire logic uart_tx,
  output var  logic scan_trigger_n,
  output var  logic host_reset_n,
  output var  logic uart_rx
);
  int         bit_cyc  = int'(scnh_pkg::DIV_DEF);
  int         stop_bad = 0;
  logic [7:0] rx_q[$];
  logic [7:0] b;

  // The receive line idles high, and no handshake lines exist.
  initial
  begin
    scan_trigger_n = 1'b1;
    host_reset_n   = 1'b1;
    uart_rx        = 1'b1;
  end

  task automatic trig(input logic lvl);
    @(posedge sys_clk);
    scan_trigger_n <= lvl;
  endtask : trig

  task automatic rst_pulse(input int n);
    @(posedge sys_clk);
    host_reset_n <= 1'b0;
    repeat (n) @(posedge sys_clk);
    host_reset_n <= 1'b1;
  endtask : rst_pulse

  task automatic rx_level(input logic lvl);
    @(posedge sys_clk);
    uart_rx <= lvl;
  endtask : rx_level

  // Samples each bit at its centre, LSB first, then checks the stop bit.
  always
  begin
    @(negedge uart_tx);
    repeat (bit_cyc / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_cyc) @(posedge sys_clk);
      b[i] = uart_tx;
    end
    repeat (bit_cyc) @(posedge sys_clk);
    if (uart_tx !== 1'b1) stop_bad++;
    rx_q.push_back(b);
  end
endmodule : scnh_host
`default_nettype wire

// *** verification/scan_engine_host_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module scan_engine_host_control_tb;
  import scnh_pkg::*;
  localparam int TRIG_P = 50;
  localparam int GAP_P  = 5000;
  localparam int LED_P  = 20;
  localparam int BEEP_P = 30;
  localparam int RMAX_P = 3000;
  localparam int TONE_P = 4;
  logic        sys_clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        scan_trigger_n, host_reset_n, uart_rx, uart_tx;
  logic        dec_valid, dec_last, dec_ready, scan_active, scan_abort;
  logic        engine_reset, good_read_led, beeper_pwm, beep_q, act_q;
  logic [7:0]  dec_data;
  logic [1:0]  usb_mode;
  int fail_count = 0, n_checks = 0;
  int n_rst = 0, n_abort = 0, n_tog = 0, n_led = 0, n_ref = 0, n_scan = 0;

  scnh_engine #(.TRIG_P(TRIG_P), .RMAX_P(RMAX_P), .GAP_P(GAP_P), .LED_P(LED_P),
    .BEEP_P(BEEP_P), .TONE_P(TONE_P)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scan_trigger_n(scan_trigger_n),
    .host_reset_n(host_reset_n), .uart_rx(uart_rx), .dec_valid(dec_valid),
    .dec_data(dec_data), .dec_last(dec_last), .dec_ready(dec_ready),
    .scan_active(scan_active), .scan_abort(scan_abort), .engine_reset(engine_reset),
    .uart_tx(uart_tx), .good_read_led(good_read_led), .beeper_pwm(beeper_pwm),
    .usb_mode(usb_mode));

  scnh_host u_host (.sys_clk(sys_clk), .uart_tx(uart_tx), .scan_trigger_n(scan_trigger_n),
    .host_reset_n(host_reset_n), .uart_rx(uart_rx));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Event counters that the scenarios read before and after each step.
  always @(posedge sys_clk)
  begin
    beep_q  <= beeper_pwm;
    act_q   <= scan_active;
    n_rst   <= n_rst + int'(engine_reset === 1'b1);
    n_abort <= n_abort + int'(scan_abort === 1'b1);
    n_led   <= n_led + int'(good_read_led === 1'b1);
    n_tog   <= n_tog + int'(beeper_pwm !== beep_q);
    n_scan  <= n_scan + int'(scan_active === 1'b1 && act_q !== 1'b1);
    n_ref   <= n_ref + int'(dec_valid && dec_ready !== 1'b1);
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic send(input logic [7:0] base, input int n);
    for (int i = 0; i < n; i++)
    begin
      dec_valid <= 1'b1;
      dec_data  <= base + 8'(i);
      dec_last  <= (i == n - 1);
      do
        @(posedge sys_clk);
      while (dec_ready !== 1'b1);
    end
    dec_valid <= 1'b0;
    @(posedge sys_clk);
  endtask : send

  task automatic wait_scan(output int lat);
    lat = 0;
    while (scan_active !== 1'b1 && lat < TRIG_P + 30)
    begin
      @(posedge sys_clk);
      lat++;
    end
  endtask : wait_scan

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (u_host.rx_q.size() < n && k < 40000)
    begin
      @(posedge sys_clk);
      k++;
    end
  endtask : wait_rx

  task automatic t_regs;
    int t;
    cyc(BEEP_P + 10);
    t = n_tog;
    chk("powerup_beep", 32'(t > 0), 1);
    cyc(40);
    chk("beep_stops", n_tog, t);
    bus(0, ADDR_CTRL, 0);
    chk("ctrl_rst", rd, 32'h4);
    bus(0, ADDR_BAUD, 0);
    chk("baud_rst", rd, 32'(DIV_DEF));
    bus(0, 4'hC, 0);
    chk("unmapped", rd, 0);
    for (int m = 0; m < 3; m++)
    begin
      bus(1, ADDR_CTRL, 32'h4 | m);
      chk("usb_mode", usb_mode, 32'(m));
    end
    bus(1, ADDR_CTRL, 32'h7);
    chk("mode3_kept", usb_mode, 2);
    bus(1, ADDR_BAUD, 32'(DIV_MIN) - 1);
    bus(1, ADDR_BAUD, 32'(DIV_MAX) + 1);
    bus(0, ADDR_BAUD, 0);
    chk("baud_range", rd, 32'(DIV_DEF));
    u_host.rx_level(1'b0);
    cyc(6);
    bus(0, ADDR_STATUS, 0);
    chk("rx_low", rd[7], 0);
    u_host.rx_level(1'b1);
    cyc(6);
    bus(0, ADDR_STATUS, 0);
    chk("rx_high", rd[7], 1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_read;
    int lat, t, l, s;
    u_host.trig(1'b0);
    cyc(20);
    u_host.trig(1'b1);
    cyc(TRIG_P + 20);
    chk("short_trig", n_scan, 0);
    u_host.trig(1'b0);
    wait_scan(lat);
    chk("scan_lat", 32'(lat > TRIG_P && lat < TRIG_P + 10), 1);
    t = n_tog;
    l = n_led;
    send(8'hA5, 1);
    cyc(LED_P + 40);
    chk("led_len", n_led - l, LED_P);
    chk("read_beep", 32'(n_tog > t), 1);
    wait_rx(1);
    chk("byte_9600", u_host.rx_q[0], 8'hA5);
    // The model takes the byte in mid stop bit; the frame ends half a bit later.
    cyc(int'(DIV_DEF) / 2 + 20);
    bus(0, ADDR_STATUS, 0);
    chk("hold_state", rd[2:0], 0);
    s = n_scan;
    cyc(TRIG_P + 20);
    chk("no_retrigger", n_scan, s);
    u_host.trig(1'b1);
    cyc(10);
    bus(0, ADDR_STATUS, 0);
    chk("idle_state", rd[2:0], 1);
    $display("test read done");
  endtask : t_read

  task automatic t_abort;
    int lat, a;
    u_host.trig(1'b0);
    wait_scan(lat);
    a = n_abort;
    u_host.trig(1'b1);
    cyc(10);
    chk("abort_pulse", n_abort - a, 1);
    chk("abort_stop", scan_active, 0);
    $display("test abort done");
  endtask : t_abort

  task automatic t_burst;
    int lat, r, t;
    bus(1, ADDR_BAUD, 32'(DIV_MIN));
    bus(1, ADDR_CTRL, 32'h0);
    t = n_tog;
    u_host.bit_cyc = int'(DIV_MIN);
    u_host.trig(1'b0);
    wait_scan(lat);
    r = n_ref;
    send(8'h30, 4);
    chk("buffer_full", 32'(n_ref > r), 1);
    wait_rx(5);
    for (int i = 0; i < 4; i++)
      chk("burst_byte", u_host.rx_q[i + 1], 8'h30 + 8'(i));
    chk("stop_bits", u_host.stop_bad, 0);
    chk("beep_off", n_tog, t);
    bus(0, ADDR_STATUS, 0);
    chk("good_reads", rd[15:8], 2);
    u_host.trig(1'b1);
    cyc(10);
    $display("test burst done");
  endtask : t_burst

  task automatic t_reset;
    int r;
    r = n_rst;
    u_host.rst_pulse(2600);
    cyc(10);
    chk("reset_ok", n_rst - r, 1);
    bus(0, ADDR_CTRL, 0);
    chk("ctrl_restored", rd, 32'h4);
    bus(0, ADDR_BAUD, 0);
    chk("baud_restored", rd, 32'(DIV_DEF));
    u_host.rst_pulse(2600);
    cyc(10);
    chk("reset_gap", n_rst - r, 1);
    cyc(GAP_P);
    u_host.rst_pulse(1000);
    cyc(10);
    u_host.rst_pulse(3100);
    cyc(10);
    chk("reset_len", n_rst - r, 1);
    u_host.rst_pulse(2600);
    cyc(10);
    chk("reset_again", n_rst - r, 2);
    $display("test reset done");
  endtask : t_reset

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    nrst          = 1'b0;
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    dec_valid     = 1'b0;
    dec_data      = 8'h00;
    dec_last      = 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_read();
    t_abort();
    t_burst();
    t_reset();
    test_done();
  end

  initial
  begin
    repeat (90000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end
endmodule : scan_engine_host_control_tb
`default_nettype wire
